//--- design/wdr_pkg.sv
/*
 * types of the watchdog and brownout reset block.
 * assumes nothing beyond the register header.
 */
package wdr_pkg;
    typedef enum logic [1:0] {
        WDR_RUN = 2'b00,
        WDR_FAULT_WAIT = 2'b01
    } wdr_fault_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdr_bus_req_t;

    typedef struct packed {
        logic full_reset;
        logic pc_sp_reset;
    } wdr_reset_out_t;
endpackage : wdr_pkg

//--- design/wdr_regs.svh
/*
 * offsets, reset values, field positions and timing counts of the watchdog and brownout reset block.
 * assumes an 8-bit register port with a 2-bit address.
 */
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH
`define WDR_OFF_WDT_CTRL 2'h0
`define WDR_OFF_CAUSE 2'h1
`define WDR_OFF_BO_LEVEL 2'h2
`define WDR_OFF_BO_FILTER 2'h3
`define WDR_RST_WDT_CTRL 8'h53
`define WDR_RST_BO_LEVEL 8'h55
`define WDR_RST_BO_FILTER 2'h1
`define WDR_KEY_MSB 7
`define WDR_KEY_LSB 3
`define WDR_SEL_MSB 2
`define WDR_KEY_A 5'h15
`define WDR_KEY_B 5'h0a
`define WDR_LVL_21 8'h55
`define WDR_LVL_255 8'h33
`define WDR_LVL_315 8'h99
`define WDR_LVL_38 8'haa
`define WDR_BIT_KEY_FAULT 0
`define WDR_BIT_THR_FAULT 1
`define WDR_BIT_BROWNOUT 2
// slow clock 32 kHz against 10 MHz system clock: 31250 ns period
`define WDR_SLOW_PERIOD_NS 31250
`define WDR_SYS_PERIOD_NS 100
`define WDR_SLOW_DIV ((`WDR_SLOW_PERIOD_NS) / (`WDR_SYS_PERIOD_NS))
`define WDR_FAULT_DELAY_SLOW 4
`endif

//--- design/wdr_top.sv
/*
 * watchdog timer, keyed software reset, brownout filter and reset cause flags.
 * assumes a synchronous register port and that the cpu reports its mode as a level and its instruction events as
 * one-cycle pulses; the slow rc clock is modelled by a divided tick of the system clock.
 */
// What this block does
// - key 10101 or 01010 enables watchdog; other keys request software reset
// - bad key waits fault delay, then resets and sets key fault flag
// - timeout select codes 000..110 pick 2^8,10,12,14,15,16,17 slow periods
// - code 111 picks longest timeout of 2^18 slow periods
// - key field powers up as 01010 so watchdog runs at once
// - key fault flag set by hardware, cleared only by software writing zero
// - overflow in normal run gives full reset and sets timeout flag
// - overflow in sleep or idle resets only pc and stack pointer
// - counter cleared by key reset, clear instruction or halt instruction
// - power-on reset loads zero into program counter
// - power-on reset sets port data and direction registers to ones
// - brownout detection works in run modes, disabled in idle or sleep
// - low supply longer than filter time resets and sets brownout flag
// - filter select 00..11 gives 8, 32, 64, 128 slow periods
// - only four level codes valid; power-on level is 01010101
// - bad level code resets after delay, sets flag, restores level
// - brownout flag set by hardware, cleared only by software
// - unused upper bits of cause and filter registers read zero
// - sleep timeout sets both timeout and power-down flags
// - halt sets power-down flag; power-up or clear instruction clears it
// - watchdog counts slow rc clock divided by timeout select
`timescale 1ns/100ps
`include "wdr_regs.svh"

module wdr_top
    import wdr_pkg::*;
#(
    parameter int SLOW_DIV = `WDR_SLOW_DIV,
    parameter int FAULT_DELAY = `WDR_FAULT_DELAY_SLOW
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // register port
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // cpu events and supply monitor
    input wire logic I_WATCHDOG_CLEAR_INSTRUCTION,
    input wire logic I_HALT,
    input wire logic I_LOW_POWER_MODE,
    input wire logic I_LOW_SUPPLY,
    // status and resets
    output logic O_TIMEOUT_FLAG,
    output logic O_POWERDOWN_FLAG,
    output logic O_FULL_RESET,
    output logic O_PC_SP_RESET,
    output logic [7:0] O_PORT_INIT
);
    wdr_bus_req_t req;
    wdr_reset_out_t rst_q;
    wdr_fault_state_t fault_state;
    logic [7:0] wdt_ctrl;
    logic [7:0] bo_level;
    logic [1:0] bo_filter;
    logic key_fault_flag;
    logic threshold_fault_flag;
    logic brownout_flag;
    logic [15:0] slow_div;
    logic slow_tick;
    logic [18:0] watchdog_counter;
    logic [7:0] fault_cnt;
    logic [7:0] bo_cnt;
    logic fault_is_key;
    logic key_ok;
    logic level_ok;
    logic wdt_overflow;
    logic bo_trip;
    logic [4:0] key;
    logic [7:0] bo_limit;

    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign key = wdt_ctrl[`WDR_KEY_MSB:`WDR_KEY_LSB];
    assign key_ok = (key == `WDR_KEY_A) || (key == `WDR_KEY_B);
    assign level_ok = (bo_level == `WDR_LVL_21) || (bo_level == `WDR_LVL_255) ||
                      (bo_level == `WDR_LVL_315) || (bo_level == `WDR_LVL_38);

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            slow_div <= 16'h0000;
        end else if (slow_div == 16'(SLOW_DIV - 1)) begin
            slow_div <= 16'h0000;
        end else begin
            slow_div <= slow_div + 16'h0001;
        end
    end
    assign slow_tick = (slow_div == 16'(SLOW_DIV - 1));

    always_comb begin
        case (wdt_ctrl[`WDR_SEL_MSB:0])
            3'h0: wdt_overflow = watchdog_counter[8];
            3'h1: wdt_overflow = watchdog_counter[10];
            3'h2: wdt_overflow = watchdog_counter[12];
            3'h3: wdt_overflow = watchdog_counter[14];
            3'h4: wdt_overflow = watchdog_counter[15];
            3'h5: wdt_overflow = watchdog_counter[16];
            3'h6: wdt_overflow = watchdog_counter[17];
            default: wdt_overflow = watchdog_counter[18];
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            watchdog_counter <= 19'h00000;
        end else if (I_WATCHDOG_CLEAR_INSTRUCTION || I_HALT || !key_ok || wdt_overflow || rst_q.full_reset) begin
            watchdog_counter <= 19'h00000;
        end else if (slow_tick) begin
            watchdog_counter <= watchdog_counter + 19'h00001;
        end
    end

    always_comb begin
        case (bo_filter)
            2'h0: bo_limit = 8'h08;
            2'h1: bo_limit = 8'h20;
            2'h2: bo_limit = 8'h40;
            default: bo_limit = 8'h80;
        endcase
    end
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bo_cnt <= 8'h00;
        end else if (!I_LOW_SUPPLY || I_LOW_POWER_MODE || bo_trip) begin
            bo_cnt <= 8'h00;
        end else if (slow_tick) begin
            bo_cnt <= bo_cnt + 8'h01;
        end
    end
    assign bo_trip = (bo_cnt == bo_limit) && I_LOW_SUPPLY && !I_LOW_POWER_MODE;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fault_state <= WDR_RUN;
            fault_cnt <= 8'h00;
            fault_is_key <= 1'b0;
        end else begin
            case (fault_state)
                WDR_RUN: begin
                    fault_cnt <= 8'h00;
                    if (!key_ok || !level_ok) begin
                        fault_state <= WDR_FAULT_WAIT;
                        fault_is_key <= !key_ok;
                    end
                end
                WDR_FAULT_WAIT: begin
                    // a cause rewritten to a legal value before the delay ends drops the pending reset,
                    // so a late firing cannot set a cause flag that software has already cleared
                    if (key_ok && level_ok) begin
                        fault_state <= WDR_RUN;
                    end else if (slow_tick) begin
                        fault_cnt <= fault_cnt + 8'h01;
                    end
                    if (slow_tick && fault_cnt == 8'(FAULT_DELAY - 1)) begin
                        fault_state <= WDR_RUN;
                    end
                    if (key_ok && level_ok) begin
                        fault_cnt <= 8'h00;
                    end
                end
                default: fault_state <= WDR_RUN;
            endcase
        end
    end

    // reset outputs, one-cycle pulses
    logic fault_fire;
    assign fault_fire = (fault_state == WDR_FAULT_WAIT) && slow_tick && (fault_cnt == 8'(FAULT_DELAY - 1)) &&
                        !(key_ok && level_ok);
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_q <= '0;
        end else begin
            // full reset in run, pc/sp reset in sleep
            rst_q.full_reset <= (wdt_overflow && !I_LOW_POWER_MODE) || bo_trip || fault_fire;
            rst_q.pc_sp_reset <= wdt_overflow && I_LOW_POWER_MODE;
        end
    end
    assign O_FULL_RESET = rst_q.full_reset;
    assign O_PC_SP_RESET = rst_q.pc_sp_reset;
    // port init value, pc zero handled by cpu on reset pulse
    assign O_PORT_INIT = 8'hff;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_TIMEOUT_FLAG <= 1'b0;
            O_POWERDOWN_FLAG <= 1'b0;
        end else if (wdt_overflow) begin
            O_TIMEOUT_FLAG <= 1'b1;
            if (I_LOW_POWER_MODE) begin
                O_POWERDOWN_FLAG <= 1'b1;
            end
        end else if (I_HALT) begin
            O_POWERDOWN_FLAG <= 1'b1;
            O_TIMEOUT_FLAG <= 1'b0;
        end else if (I_WATCHDOG_CLEAR_INSTRUCTION) begin
            O_POWERDOWN_FLAG <= 1'b0;
            O_TIMEOUT_FLAG <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wdt_ctrl <= `WDR_RST_WDT_CTRL;
        end else if (req.wr && req.addr == `WDR_OFF_WDT_CTRL) begin
            wdt_ctrl <= req.wdata;
        end
    end

    // level register restored after level fault reset, not after key fault reset
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bo_level <= `WDR_RST_BO_LEVEL;
            bo_filter <= `WDR_RST_BO_FILTER;
        end else if (fault_fire && !fault_is_key) begin
            bo_level <= `WDR_RST_BO_LEVEL;
        end else if (req.wr && req.addr == `WDR_OFF_BO_LEVEL) begin
            bo_level <= req.wdata;
        end else if (req.wr && req.addr == `WDR_OFF_BO_FILTER) begin
            bo_filter <= req.wdata[1:0];
        end
    end

    // sticky cause flags, set wins over clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            key_fault_flag <= 1'b0;
            threshold_fault_flag <= 1'b0;
            brownout_flag <= 1'b0;
        end else begin
            if (fault_fire && fault_is_key) begin
                key_fault_flag <= 1'b1;
            end else if (req.wr && req.addr == `WDR_OFF_CAUSE && !req.wdata[`WDR_BIT_KEY_FAULT]) begin
                key_fault_flag <= 1'b0;
            end
            if (fault_fire && !fault_is_key) begin
                threshold_fault_flag <= 1'b1;
            end else if (req.wr && req.addr == `WDR_OFF_CAUSE && !req.wdata[`WDR_BIT_THR_FAULT]) begin
                threshold_fault_flag <= 1'b0;
            end
            if (bo_trip) begin
                brownout_flag <= 1'b1;
            end else if (req.wr && req.addr == `WDR_OFF_CAUSE && !req.wdata[`WDR_BIT_BROWNOUT]) begin
                brownout_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `WDR_OFF_WDT_CTRL: O_RDATA <= wdt_ctrl;
                `WDR_OFF_CAUSE: O_RDATA <= {5'h00, brownout_flag, threshold_fault_flag, key_fault_flag};
                `WDR_OFF_BO_LEVEL: O_RDATA <= bo_level;
                default: O_RDATA <= {6'h00, bo_filter};
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end
endmodule : wdr_top

//--- tb/watchdog_and_brownout_reset_tb.sv
/*
 * random and corner tests of the watchdog and brownout reset block.
 * assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
module watchdog_and_brownout_reset_tb;
    localparam int SD = 4;
    localparam int FD = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic halt = 1'b0;
    logic lp = 1'b0;
    logic low = 1'b0;
    logic [7:0] rdata;
    logic [7:0] pinit;
    logic tout, pdown, full, pcsp;
    logic [7:0] v;
    logic [7:0] lvls [4] = '{8'h33, 8'h99, 8'haa, 8'h55};
    int errors = 0;
    int compares = 0;
    int resets = 0;
    int n;
    always #50 clk = ~clk;
    always @(posedge clk) if (full || pcsp) resets++;
    wdr_top #(.SLOW_DIV(SD), .FAULT_DELAY(FD)) wdr_top_inst (.I_SYS_CLK(clk), .I_RST_N(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_WATCHDOG_CLEAR_INSTRUCTION(clr),
        .I_HALT(halt), .I_LOW_POWER_MODE(lp), .I_LOW_SUPPLY(low), .O_TIMEOUT_FLAG(tout),
        .O_POWERDOWN_FLAG(pdown), .O_FULL_RESET(full), .O_PC_SP_RESET(pcsp), .O_PORT_INIT(pinit));
    function automatic int tbits(input int s);
        return s < 4 ? 8 + 2 * s : 11 + s;
    endfunction : tbits
    function automatic int flim(input int f);
        return f == 0 ? 8 : 16 << f;
    endfunction : flim
    task automatic close_out;
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    task automatic pulse(input logic h);
        @(posedge clk);
        if (h) halt <= 1'b1;
        else clr <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        clr <= 1'b0;
    endtask : pulse
    // cycles until a reset pulse shows, bounded
    task automatic wait_rst(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1 cnt++;
        end while (!(full || pcsp) && cnt <= lim);
        if (cnt > lim) begin
            errors++;
            close_out();
        end
    endtask : wait_rst
    initial begin
        void'($urandom(32'h292d2225));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(2'h0, 8'h53);
        rd_chk(2'h2, 8'h55);
        rd_chk(2'h3, 8'h01);
        rd_chk(2'h1, 8'h00);
        chk(pinit, 8'hff);
        wr_reg(2'h3, 8'hff);
        rd_chk(2'h3, 8'h03);
        foreach (lvls[i]) begin
            wr_reg(2'h2, lvls[i]);
            rd_chk(2'h2, lvls[i]);
        end
        do v = 8'($urandom); while (v[7:3] == 5'h15 || v[7:3] == 5'h0a);
        wr_reg(2'h0, v);
        wait_rst(FD * SD + SD + 8, n);
        chk({full, n >= FD * SD - SD}, 2'b11);
        wr_reg(2'h0, 8'hab);
        rd_chk(2'h1, 8'h01);
        wr_reg(2'h1, 8'h00);
        rd_chk(2'h1, 8'h00);
        wr_reg(2'h2, 8'h12);
        wait_rst(FD * SD + SD + 8, n);
        chk(full, 1'b1);
        rd_chk(2'h2, 8'h55);
        rd_chk(2'h1, 8'h02);
        wr_reg(2'h1, 8'h00);
        for (int s = 0; s < 3; s++) begin
            wr_reg(2'h0, {s[0] ? 5'h15 : 5'h0a, 3'(s)});
            pulse(1'b0);
            wait_rst((SD << tbits(s)) + 20, n);
            chk(n >= (SD << tbits(s)) - SD - 2 && n <= (SD << tbits(s)) + SD + 2, 1'b1);
            chk({full, tout}, 2'b11);
        end
        wr_reg(2'h0, 8'h50);
        n = resets;
        repeat (6) begin
            repeat ($urandom % 800 + 50) @(posedge clk);
            pulse(1'($urandom));
        end
        chk(resets - n, 0);
        @(posedge clk);
        lp <= 1'b1;
        low <= 1'b1;
        pulse(1'b1);
        #1 chk({pdown, tout}, 2'b10);
        wait_rst(SD * 256 + 20, n);
        chk({pcsp, full}, 2'b10);
        chk({tout, pdown}, 2'b11);
        @(posedge clk);
        lp <= 1'b0;
        low <= 1'b0;
        pulse(1'b0);
        #1 chk({tout, pdown}, 2'b00);
        rd_chk(2'h1, 8'h00);
        wr_reg(2'h0, 8'haf);
        pulse(1'b0);
        for (int f = 0; f < 4; f++) begin
            wr_reg(2'h3, 8'(f));
            n = resets;
            @(posedge clk);
            low <= 1'b1;
            repeat ((flim(f) - 2) * SD) @(posedge clk);
            low <= 1'b0;
            repeat (4) @(posedge clk);
            chk(resets - n, 0);
            low <= 1'b1;
            wait_rst((flim(f) + 2) * SD + 8, n);
            low <= 1'b0;
            chk(n >= (flim(f) - 1) * SD, 1'b1);
            rd_chk(2'h1, 8'h04);
            rd_chk(2'h2, 8'h55);
            wr_reg(2'h1, 8'h00);
        end
        close_out();
    end
endmodule : watchdog_and_brownout_reset_tb

//--- tb/wdr_top_asserts.sv
/*
 * port checker of the watchdog and brownout reset block.
 * assumes the top module ports and a reduced slow tick divider.
 */
`timescale 1ns/100ps
module wdr_top_asserts
    import wdr_pkg::*;
#(
    parameter int SLOW_DIV = 4
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // register port
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    // cpu events and supply
    input wire logic I_WATCHDOG_CLEAR_INSTRUCTION,
    input wire logic I_HALT,
    input wire logic I_LOW_POWER_MODE,
    input wire logic I_LOW_SUPPLY,
    // status and resets
    input wire logic O_TIMEOUT_FLAG,
    input wire logic O_POWERDOWN_FLAG,
    input wire logic O_FULL_RESET,
    input wire logic O_PC_SP_RESET,
    input wire logic [7:0] O_PORT_INIT
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    // cycles since the last clear or halt, saturating
    logic [15:0] since_clr;
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) since_clr <= 16'h0000;
        else if (I_WATCHDOG_CLEAR_INSTRUCTION || I_HALT) since_clr <= 16'h0000;
        else if (since_clr != 16'hffff) since_clr <= since_clr + 16'h0001;
    end
    a_port_ones: assert property (O_PORT_INIT == 8'hff)
        else $error("port init value wrong");
    a_upper_zero: assert property ($past(I_RD) && $past(I_ADDR[0]) |-> O_RDATA[7:3] == 5'h00 &&
        !(O_RDATA[2] && $past(I_ADDR[1]))) else $error("unused bits not zero");
    a_rd_quiet: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside read cycle");
    a_full_once: assert property (O_FULL_RESET |=> !O_FULL_RESET)
        else $error("full reset longer than one cycle");
    a_pcsp_once: assert property (O_PC_SP_RESET |=> !O_PC_SP_RESET)
        else $error("pc reset longer than one cycle");
    a_sleep_flags: assert property (O_PC_SP_RESET |-> ##[0:1] (O_TIMEOUT_FLAG && O_POWERDOWN_FLAG))
        else $error("sleep timeout flags missing");
    a_halt_pd: assert property (I_HALT |=> O_POWERDOWN_FLAG && !O_TIMEOUT_FLAG)
        else $error("halt flags wrong");
    a_clr_flags: assert property (I_WATCHDOG_CLEAR_INSTRUCTION && !I_HALT |=> !O_POWERDOWN_FLAG && !O_TIMEOUT_FLAG)
        else $error("clear did not drop flags");
    a_tout_early: assert property ($rose(O_TIMEOUT_FLAG) |-> since_clr >= 16'(255 * SLOW_DIV))
        else $error("timeout before shortest period");
    c_full: cover property (O_FULL_RESET);
    c_pcsp: cover property (O_PC_SP_RESET);
    c_pdown: cover property ($rose(O_POWERDOWN_FLAG));
endmodule : wdr_top_asserts

bind wdr_top wdr_top_asserts #(.SLOW_DIV(SLOW_DIV)) wdr_top_asserts_inst (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_WATCHDOG_CLEAR_INSTRUCTION(I_WATCHDOG_CLEAR_INSTRUCTION), .I_HALT(I_HALT),
    .I_LOW_POWER_MODE(I_LOW_POWER_MODE), .I_LOW_SUPPLY(I_LOW_SUPPLY), .O_TIMEOUT_FLAG(O_TIMEOUT_FLAG),
    .O_POWERDOWN_FLAG(O_POWERDOWN_FLAG), .O_FULL_RESET(O_FULL_RESET), .O_PC_SP_RESET(O_PC_SP_RESET),
    .O_PORT_INIT(O_PORT_INIT));
